//--- hw/scp_command_parser.sv
`timescale 1ns/10ps
`include "scp_cfg.svh"
// Notes on behaviour
// [R1] serial 8N1 at 38400, or 9600 when the slow-rate bit is set
// [R2] no handshake lines; only receive and transmit data pins
// [R3] serial replies and display writes never overlap
// [R4] mask output high for the whole display write
// [R5] host must tolerate queries dropped during display writes
// [R6] frame is two-character code, optional parameter, semicolon; bare code queries
// [R7] parameter between code and semicolon sets the named setting
// [R8] unknown code answers question mark then semicolon
// [R9] replies end in semicolon, never carriage return or line feed
// [R10] set on read-only command ignored, answered like a query
// [R11] frequencies stored without range checking
// [R12] audio gain query always answers four zeros
// [R13] aux set: bit 0 to output 0, bit 1 to output 1
// [R14] aux query: written value, plus 4 voltmeter, plus 32 counter
// [R15] vfo frequency set stores decimal hertz, query answers 11 digits
// [R16] mode set parameter 0, 1, 2 selects A, B, split
// [R17] receive mode query: 1 only in mode B
// [R18] transmit mode query: 0 only in mode A
// [R19] filter width query always answers 0200
// [R20] info query answers fixed composite field order
// [R21] info frequency picked from mode and transmit state
// [R22] info offset field is sign and four digits, at most 9999
// [R23] info split flag 1 only in split mode
// [R24] frame longer than buffer is discarded up to its semicolon
// [R25] reply queued after whole frame parsed, characters sent back to back
module scp_command_parser #(
  parameter logic [`SCP_CNT_W-1:0] SLOW_BIT_CYC = `SCP_CNT_W'(`SCP_BIT_CYC(`SCP_BAUD_SLOW))
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic displayBitSharedRx,
  output logic displayBitSharedTx,
  output logic maskOut,
  input wire logic dispReq,
  output logic dispGrant,
  input wire logic voltmeterInput,
  input wire logic counterInput,
  output logic auxOutput0,
  output logic auxOutput1
);
  localparam logic [`SCP_CNT_W-1:0] FAST_BIT_CYC = `SCP_CNT_W'(`SCP_BIT_CYC(`SCP_BAUD_FAST));

  function automatic logic [7:0] asc(input logic [3:0] d);
    asc = `SCP_CH_ZERO + {4'h0, d};
  endfunction : asc

  // pos 0 is the most significant of the 11 digits
  function automatic logic [3:0] bcdDigit(input logic [43:0] v, input logic [5:0] pos);
    bcdDigit = 4'(v >> {6'(6'd10 - pos), 2'b00});
  endfunction : bcdDigit

  logic [31:0] ctrl_r;
  logic dispGrant_r;
  scp_pkg::scp_rx_e rxState_r;
  logic [`SCP_CNT_W-1:0] rxCnt_r;
  logic [2:0] rxBitIdx_r;
  logic [7:0] rxShift_r;
  logic rxValid_r;
  logic [4:0] frameCnt_r;
  logic frameOvf_r;
  logic [7:0] code0_r;
  logic [7:0] code1_r;
  logic [43:0] paramBcd_r;
  logic [1:0] paramMod4_r;
  logic [3:0] paramLast_r;
  logic [43:0] vfoAHz_r;
  logic [43:0] vfoBHz_r;
  scp_pkg::scp_vfo_e vfoMode_r;
  logic [1:0] aux_r;
  scp_pkg::scp_cmd_e replyCmd_r;
  logic axCounter_r;
  logic [3:0] axLow_r;
  scp_pkg::scp_send_e sendState_r;
  logic [5:0] buildIdx_r;
  logic [5:0] sendIdx_r;
  logic [9:0] txShift_r;
  logic [3:0] txBitsLeft_r;
  logic [`SCP_CNT_W-1:0] txCnt_r;
  logic [7:0] memRdData;
  logic [`SCP_CNT_W-1:0] bitCyc;
  logic frameDone;
  logic frameIsSet;
  logic replyNeeded;
  scp_pkg::scp_cmd_e frameCmd;
  logic [5:0] replyLen;
  logic [7:0] replyChar;
  logic rxVfoB;
  logic txVfoB;
  logic [43:0] infoHz;
  logic txStart;
  logic txEnd;
  logic apbAccess;
  logic apbMapped;

  assign bitCyc = ctrl_r[`SCP_CTRL_BAUD_SLOW] ? SLOW_BIT_CYC : FAST_BIT_CYC; // [R1]

  // ---------------- apb slave, answers in the access cycle
  assign apbAccess = psel && penable;
  assign apbMapped = (paddr == `SCP_OFS_CTRL) || (paddr == `SCP_OFS_STATUS) ||
                     (paddr == `SCP_OFS_VFO_A) || (paddr == `SCP_OFS_VFO_B);
  assign pready = 1'b1;
  assign pslverr = apbAccess && !apbMapped;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `SCP_CTRL_RST;
    end else if (apbAccess && pwrite && paddr == `SCP_OFS_CTRL) begin
      ctrl_r <= pwdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `SCP_OFS_CTRL: prdata <= ctrl_r;
        `SCP_OFS_STATUS: prdata <= {26'h0, sendState_r != scp_pkg::SND_IDLE, dispGrant_r,
                                    aux_r, vfoMode_r};
        `SCP_OFS_VFO_A: prdata <= vfoAHz_r[31:0];
        `SCP_OFS_VFO_B: prdata <= vfoBHz_r[31:0];
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------- display arbitration: whole replies are atomic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dispGrant_r <= 1'b0;
    end else begin
      dispGrant_r <= dispReq && (dispGrant_r || sendState_r != scp_pkg::SND_SEND); // [R3]
    end
  end
  assign dispGrant = dispGrant_r;
  assign maskOut = dispGrant_r; // [R4]

  // ---------------- receiver; characters during a display write are lost
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxState_r <= scp_pkg::RX_IDLE;
      rxCnt_r <= '0;
      rxBitIdx_r <= 3'h0;
      rxShift_r <= 8'h00;
      rxValid_r <= 1'b0;
    end else begin
      rxValid_r <= 1'b0;
      if (dispGrant_r) begin
        rxState_r <= scp_pkg::RX_IDLE; // [R5]
      end else begin
        unique case (rxState_r)
          scp_pkg::RX_IDLE: begin
            rxCnt_r <= '0;
            if (!displayBitSharedRx) begin
              rxState_r <= scp_pkg::RX_START;
            end
          end
          scp_pkg::RX_START: begin
            rxCnt_r <= rxCnt_r + 1'b1;
            if (rxCnt_r == (bitCyc >> 1)) begin
              rxCnt_r <= '0;
              rxBitIdx_r <= 3'h0;
              rxState_r <= displayBitSharedRx ? scp_pkg::RX_IDLE : scp_pkg::RX_DATA;
            end
          end
          scp_pkg::RX_DATA: begin
            rxCnt_r <= rxCnt_r + 1'b1;
            if (rxCnt_r == bitCyc - 1'b1) begin
              rxCnt_r <= '0;
              rxShift_r <= {displayBitSharedRx, rxShift_r[7:1]}; // [R1]
              rxBitIdx_r <= rxBitIdx_r + 1'b1;
              if (rxBitIdx_r == 3'h7) begin
                rxState_r <= scp_pkg::RX_STOP;
              end
            end
          end
          scp_pkg::RX_STOP: begin
            rxCnt_r <= rxCnt_r + 1'b1;
            if (rxCnt_r == bitCyc - 1'b1) begin
              rxValid_r <= displayBitSharedRx; // framing error drops the character
              rxState_r <= scp_pkg::RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ---------------- frame parser
  always_comb begin
    unique case ({code0_r, code1_r})
      `SCP_CODE_AUDIO_GAIN: frameCmd = scp_pkg::CMD_AUDIO_GAIN;
      `SCP_CODE_AUX_PIN: frameCmd = scp_pkg::CMD_AUX_PIN;
      `SCP_CODE_VFO_A_HZ: frameCmd = scp_pkg::CMD_VFO_A_HZ;
      `SCP_CODE_VFO_B_HZ: frameCmd = scp_pkg::CMD_VFO_B_HZ;
      `SCP_CODE_RX_VFO_MODE: frameCmd = scp_pkg::CMD_RX_VFO_MODE;
      `SCP_CODE_TX_VFO_MODE: frameCmd = scp_pkg::CMD_TX_VFO_MODE;
      `SCP_CODE_FILTER_WIDTH: frameCmd = scp_pkg::CMD_FILTER_WIDTH;
      `SCP_CODE_RADIO_IDENTITY: frameCmd = scp_pkg::CMD_RADIO_IDENTITY;
      `SCP_CODE_INFO: frameCmd = scp_pkg::CMD_INFO;
      default: frameCmd = scp_pkg::CMD_UNKNOWN; // [R8]
    endcase
  end

  // a frame arriving while a reply is still pending is dropped
  assign frameDone = rxValid_r && rxShift_r == `SCP_CH_SEMI && !frameOvf_r &&
                     frameCnt_r >= 5'd2 && sendState_r == scp_pkg::SND_IDLE; // [R6] [R24]
  assign frameIsSet = frameCnt_r > 5'd2; // [R7]
  assign replyNeeded = !frameIsSet || !(frameCmd inside {scp_pkg::CMD_AUX_PIN,
                       scp_pkg::CMD_VFO_A_HZ, scp_pkg::CMD_VFO_B_HZ,
                       scp_pkg::CMD_RX_VFO_MODE, scp_pkg::CMD_TX_VFO_MODE}); // [R10]

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      frameCnt_r <= 5'd0;
      frameOvf_r <= 1'b0;
      code0_r <= 8'h00;
      code1_r <= 8'h00;
      paramBcd_r <= 44'h0;
      paramMod4_r <= 2'h0;
      paramLast_r <= 4'h0;
    end else if (rxValid_r) begin
      if (rxShift_r == `SCP_CH_SEMI) begin
        frameCnt_r <= 5'd0;
        frameOvf_r <= 1'b0;
        paramBcd_r <= 44'h0;
        paramMod4_r <= 2'h0;
      end else if (frameCnt_r == `SCP_FRAME_MAX) begin
        frameOvf_r <= 1'b1; // [R24]
      end else begin
        frameCnt_r <= frameCnt_r + 5'd1;
        if (frameCnt_r == 5'd0) begin
          code0_r <= rxShift_r;
        end else if (frameCnt_r == 5'd1) begin
          code1_r <= rxShift_r;
        end else begin
          // no digit check: minimal validation
          paramBcd_r <= {paramBcd_r[39:0], rxShift_r[3:0]}; // [R11]
          paramMod4_r <= 2'({paramMod4_r, 1'b0} + {1'b0, rxShift_r[1:0]});
          paramLast_r <= rxShift_r[3:0];
        end
      end
    end
  end

  // ---------------- settings written by set frames
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vfoAHz_r <= 44'h0;
      vfoBHz_r <= 44'h0;
      vfoMode_r <= scp_pkg::VFO_A;
      aux_r <= 2'h0;
    end else if (frameDone && frameIsSet) begin
      unique case (frameCmd)
        scp_pkg::CMD_VFO_A_HZ: vfoAHz_r <= paramBcd_r; // [R15] [R11]
        scp_pkg::CMD_VFO_B_HZ: vfoBHz_r <= paramBcd_r; // [R15] [R11]
        scp_pkg::CMD_AUX_PIN: aux_r <= paramMod4_r; // [R13]
        scp_pkg::CMD_RX_VFO_MODE, scp_pkg::CMD_TX_VFO_MODE: begin
          if (paramLast_r <= 4'h2) begin
            vfoMode_r <= scp_pkg::scp_vfo_e'(paramLast_r[1:0]); // [R16]
          end
        end
        default: ;
      endcase
    end
  end
  assign auxOutput0 = aux_r[0]; // [R13]
  assign auxOutput1 = aux_r[1]; // [R13]

  // ---------------- reply assembly
  assign rxVfoB = vfoMode_r == scp_pkg::VFO_B; // [R17]
  assign txVfoB = vfoMode_r != scp_pkg::VFO_A; // [R18]
  assign infoHz = (ctrl_r[`SCP_CTRL_TX_STATE] ? txVfoB : rxVfoB) ? vfoBHz_r : vfoAHz_r; // [R21]

  always_comb begin
    unique case (replyCmd_r)
      scp_pkg::CMD_AUDIO_GAIN, scp_pkg::CMD_FILTER_WIDTH: replyLen = `SCP_LEN_FOUR;
      scp_pkg::CMD_AUX_PIN: replyLen = axCounter_r ? `SCP_LEN_SHORT + 6'd1 : `SCP_LEN_SHORT;
      scp_pkg::CMD_VFO_A_HZ, scp_pkg::CMD_VFO_B_HZ: replyLen = `SCP_LEN_HZ;
      scp_pkg::CMD_RX_VFO_MODE, scp_pkg::CMD_TX_VFO_MODE: replyLen = `SCP_LEN_SHORT;
      scp_pkg::CMD_RADIO_IDENTITY: replyLen = `SCP_LEN_IDENT;
      scp_pkg::CMD_INFO: replyLen = `SCP_LEN_INFO;
      default: replyLen = `SCP_LEN_UNKNOWN;
    endcase
  end

  always_comb begin
    replyChar = `SCP_CH_ZERO; // [R12] [R20]
    if (buildIdx_r == replyLen - 6'd1) begin
      replyChar = `SCP_CH_SEMI; // [R9]
    end else if (replyCmd_r == scp_pkg::CMD_UNKNOWN) begin
      replyChar = `SCP_CH_QUES; // [R8]
    end else if (buildIdx_r == 6'd0) begin
      replyChar = code0_r;
    end else if (buildIdx_r == 6'd1) begin
      replyChar = code1_r;
    end else begin
      unique case (replyCmd_r)
        scp_pkg::CMD_AUX_PIN: replyChar = (axCounter_r && buildIdx_r == 6'd2) ?
                                          asc(`SCP_AUX_HI_DIGIT) : asc(axLow_r); // [R14]
        scp_pkg::CMD_VFO_A_HZ: replyChar = asc(bcdDigit(vfoAHz_r, buildIdx_r - 6'd2)); // [R15]
        scp_pkg::CMD_VFO_B_HZ: replyChar = asc(bcdDigit(vfoBHz_r, buildIdx_r - 6'd2)); // [R15]
        scp_pkg::CMD_RX_VFO_MODE: replyChar = asc({3'h0, rxVfoB}); // [R17]
        scp_pkg::CMD_TX_VFO_MODE: replyChar = asc({3'h0, txVfoB}); // [R18]
        scp_pkg::CMD_FILTER_WIDTH: begin
          if (buildIdx_r == 6'd3) begin
            replyChar = asc(`SCP_FILTER_DIGIT); // [R19]
          end
        end
        scp_pkg::CMD_RADIO_IDENTITY:
          replyChar = asc(4'(`SCP_RADIO_IDENTITY >> {6'(6'd4 - buildIdx_r), 2'b00}));
        scp_pkg::CMD_INFO: begin
          if (buildIdx_r <= 6'd12) begin
            replyChar = asc(bcdDigit(infoHz, buildIdx_r - 6'd2)); // [R20] [R21]
          end else if (buildIdx_r <= 6'd17 || buildIdx_r == 6'd35) begin
            replyChar = `SCP_CH_SPACE; // [R20]
          end else if (buildIdx_r == 6'd18) begin
            replyChar = ctrl_r[`SCP_CTRL_OFS_NEG] ? `SCP_CH_MINUS : `SCP_CH_PLUS; // [R22]
          end else if (buildIdx_r <= 6'd22) begin
            // digits above nine read as nine, so the field never passes 9999
            replyChar = asc(4'(ctrl_r[31:`SCP_CTRL_OFS_LSB] >> {6'(6'd22 - buildIdx_r),
                        2'b00}) > 4'h9 ? 4'h9 : 4'(ctrl_r[31:`SCP_CTRL_OFS_LSB] >>
                        {6'(6'd22 - buildIdx_r), 2'b00})); // [R22]
          end else if (buildIdx_r == 6'd23) begin
            replyChar = asc({3'h0, ctrl_r[`SCP_CTRL_OFS_ON]}); // [R20]
          end else if (buildIdx_r == 6'd28) begin
            replyChar = asc({3'h0, ctrl_r[`SCP_CTRL_TX_STATE]}); // [R20]
          end else if (buildIdx_r == 6'd29) begin
            replyChar = asc(`SCP_CW_MODE); // [R20]
          end else if (buildIdx_r == 6'd30) begin
            replyChar = asc({3'h0, rxVfoB}); // [R20]
          end else if (buildIdx_r == 6'd32) begin
            replyChar = asc({3'h0, vfoMode_r == scp_pkg::VFO_SPLIT}); // [R23]
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------- reply sequencing
  assign txEnd = txBitsLeft_r == 4'd1 && txCnt_r == bitCyc - 1'b1;
  assign txStart = (sendState_r == scp_pkg::SND_HOLD && !dispGrant_r && !dispReq) ||
                   (sendState_r == scp_pkg::SND_SEND && txEnd && sendIdx_r != replyLen);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sendState_r <= scp_pkg::SND_IDLE;
      replyCmd_r <= scp_pkg::CMD_UNKNOWN;
      axCounter_r <= 1'b0;
      axLow_r <= 4'h0;
      buildIdx_r <= 6'd0;
      sendIdx_r <= 6'd0;
    end else begin
      unique case (sendState_r)
        scp_pkg::SND_IDLE: begin
          if (frameDone && replyNeeded) begin
            replyCmd_r <= frameCmd; // [R25]
            axCounter_r <= counterInput; // [R14]
            // inputs sampled once, so the reply cannot change mid build
            axLow_r <= {1'b0, voltmeterInput, aux_r} +
                       (counterInput ? 4'h2 : 4'h0); // [R14]
            buildIdx_r <= 6'd0;
            sendIdx_r <= 6'd0;
            sendState_r <= scp_pkg::SND_BUILD;
          end
        end
        scp_pkg::SND_BUILD: begin
          buildIdx_r <= buildIdx_r + 6'd1;
          if (buildIdx_r == replyLen - 6'd1) begin
            sendState_r <= scp_pkg::SND_HOLD;
          end
        end
        scp_pkg::SND_HOLD: begin
          if (txStart) begin
            sendIdx_r <= 6'd1;
            sendState_r <= scp_pkg::SND_SEND;
          end
        end
        scp_pkg::SND_SEND: begin
          if (txStart) begin
            sendIdx_r <= sendIdx_r + 6'd1; // [R25]
          end else if (txEnd) begin
            sendState_r <= scp_pkg::SND_IDLE;
          end
        end
      endcase
    end
  end

  // idle shifter holds ones, so the line rests high between replies
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txShift_r <= 10'h3FF;
      txBitsLeft_r <= 4'd0;
      txCnt_r <= '0;
    end else if (txStart) begin
      txShift_r <= {1'b1, memRdData, 1'b0}; // [R1]
      txBitsLeft_r <= 4'd10;
      txCnt_r <= '0;
    end else if (txBitsLeft_r != 4'd0) begin
      txCnt_r <= txCnt_r + 1'b1;
      if (txCnt_r == bitCyc - 1'b1) begin
        txCnt_r <= '0;
        txShift_r <= {1'b1, txShift_r[9:1]};
        txBitsLeft_r <= txBitsLeft_r - 4'd1;
      end
    end
  end
  assign displayBitSharedTx = txShift_r[0]; // [R2]

  scp_reply_mem u_mem (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wrEn(sendState_r == scp_pkg::SND_BUILD),
    .wrAddr(buildIdx_r),
    .wrData(replyChar),
    .rdAddr(sendIdx_r),
    .rdData(memRdData)
  );

  // ---------------- assertions
  sequence seqBuildDone;
    sendState_r == scp_pkg::SND_BUILD ##[1:40] sendState_r == scp_pkg::SND_HOLD;
  endsequence

  AST_MASK_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R4]
    dispGrant |-> maskOut && displayBitSharedTx) else $error("line not masked in display write");
  AST_NO_TX_IN_DISPLAY: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    txStart |-> !dispGrant_r && (sendState_r == scp_pkg::SND_SEND || !dispReq))
    else $error("serial start during display write");
  AST_GRANT_WHEN_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    $rose(dispGrant_r) |-> $past(sendState_r) != scp_pkg::SND_SEND)
    else $error("display granted mid reply");
  AST_AUX_SET: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R13]
    frameDone && frameIsSet && frameCmd == scp_pkg::CMD_AUX_PIN |=>
    {auxOutput1, auxOutput0} == $past(paramMod4_r)) else $error("aux outputs not set");
  AST_UNKNOWN_SHORT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R8]
    frameDone && frameCmd == scp_pkg::CMD_UNKNOWN |=> replyLen == 6'd2 ##1
    replyChar == `SCP_CH_SEMI) else $error("unknown reply wrong");
  AST_NO_CRLF: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R9]
    sendState_r == scp_pkg::SND_BUILD |-> replyChar != `SCP_CH_CR && replyChar != `SCP_CH_LF)
    else $error("line end character in reply");
  AST_SPLIT_SET: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
    frameDone && frameIsSet && frameCmd == scp_pkg::CMD_TX_VFO_MODE && paramLast_r == 4'h2
    |=> vfoMode_r == scp_pkg::VFO_SPLIT && txVfoB && !rxVfoB) else $error("split not selected");
  AST_OVERFLOW_DROP: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R24]
    frameOvf_r && rxValid_r |-> !frameDone) else $error("overflowed frame accepted");
  AST_REPLY_AFTER_PARSE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R25]
    frameDone && replyNeeded |=> seqBuildDone) else $error("reply not assembled in time");
endmodule : scp_command_parser

//--- pkg/scp_cfg.svh
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// serial timing
`define SCP_CLK_HZ 40000000
`define SCP_BAUD_FAST 38400
`define SCP_BAUD_SLOW 9600
`define SCP_BIT_CYC(b) ((`SCP_CLK_HZ + (b) / 2) / (b))
`define SCP_CNT_W 13

// frame and reply sizes
`define SCP_FRAME_MAX 5'd16
`define SCP_MEM_AW 6
`define SCP_LEN_SHORT 6'd4
`define SCP_LEN_FOUR 6'd7
`define SCP_LEN_HZ 6'd14
`define SCP_LEN_IDENT 6'd6
`define SCP_LEN_INFO 6'd37
`define SCP_LEN_UNKNOWN 6'd2

// value is arbitrary
`define SCP_RADIO_IDENTITY 12'h123
`define SCP_CW_MODE 4'h3
`define SCP_FILTER_DIGIT 4'h2
`define SCP_AUX_HI_DIGIT 4'h3

// two-character command codes
`define SCP_CODE_AUDIO_GAIN 16'h4147
`define SCP_CODE_AUX_PIN 16'h4158
`define SCP_CODE_VFO_A_HZ 16'h4641
`define SCP_CODE_VFO_B_HZ 16'h4642
`define SCP_CODE_RX_VFO_MODE 16'h4652
`define SCP_CODE_TX_VFO_MODE 16'h4654
`define SCP_CODE_FILTER_WIDTH 16'h4657
`define SCP_CODE_RADIO_IDENTITY 16'h4944
`define SCP_CODE_INFO 16'h4946

// characters
`define SCP_CH_SEMI 8'h3B
`define SCP_CH_QUES 8'h3F
`define SCP_CH_SPACE 8'h20
`define SCP_CH_ZERO 8'h30
`define SCP_CH_PLUS 8'h2B
`define SCP_CH_MINUS 8'h2D
`define SCP_CH_CR 8'h0D
`define SCP_CH_LF 8'h0A

// apb map
`define SCP_OFS_CTRL 12'h000
`define SCP_OFS_STATUS 12'h004
`define SCP_OFS_VFO_A 12'h008
`define SCP_OFS_VFO_B 12'h00C
`define SCP_CTRL_RST 32'h0000_0000
`define SCP_CTRL_BAUD_SLOW 0
`define SCP_CTRL_TX_STATE 1
`define SCP_CTRL_OFS_ON 2
`define SCP_CTRL_OFS_NEG 3
`define SCP_CTRL_OFS_LSB 16

`endif

//--- pkg/scp_pkg.sv
package scp_pkg;
  typedef enum logic [1:0] {VFO_A, VFO_B, VFO_SPLIT} scp_vfo_e;
  typedef enum logic [3:0] {
    CMD_AUDIO_GAIN, CMD_AUX_PIN, CMD_VFO_A_HZ, CMD_VFO_B_HZ, CMD_RX_VFO_MODE,
    CMD_TX_VFO_MODE, CMD_FILTER_WIDTH, CMD_RADIO_IDENTITY, CMD_INFO, CMD_UNKNOWN
  } scp_cmd_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scp_rx_e;
  typedef enum logic [1:0] {SND_IDLE, SND_BUILD, SND_HOLD, SND_SEND} scp_send_e;
endpackage : scp_pkg

//--- hw/scp_reply_mem.sv
`timescale 1ns/10ps
`include "scp_cfg.svh"
module scp_reply_mem (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [`SCP_MEM_AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [`SCP_MEM_AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:(1<<`SCP_MEM_AW)-1];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 8'hFF;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : scp_reply_mem

//--- dv/scp_host_model.sv
`timescale 1ns/10ps
module scp_host_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic sys_clk,
  input wire logic serialIn,
  output logic serialOut
);
  byte rxQ[$];

  // only data lines, no handshake pins
  initial serialOut = 1'b1;

  task automatic send_str(input string s);
    byte ch;
    for (int i = 0; i < s.len(); i++) begin
      ch = s[i];
      for (int b = 0; b < 10; b++) begin
        serialOut <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : ch[b-1];
        repeat (BIT_CYC) @(posedge sys_clk);
      end
    end
  endtask : send_str

  // mid-bit sampling; a bad stop bit drops the char
  always @(negedge serialIn) begin : rxChar
    logic [7:0] c;
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int b = 0; b < 8; b++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      c[b] = serialIn;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
    if (serialIn) begin
      rxQ.push_back(c);
    end
  end
endmodule : scp_host_model

//--- dv/serial_remote_command_parser_tb.sv
`timescale 1ns/10ps
`include "scp_cfg.svh"
module serial_remote_command_parser_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rxLine, txLine, maskOut, dispGrant, auxOutput0, auxOutput1;
  logic dispReq = 1'b0;
  logic voltmeterInput = 1'b0;
  logic counterInput = 1'b0;
  int failures = 0;
  int checked = 0;
  string f;

  always #12.5 sys_clk = ~sys_clk;

  scp_command_parser #(.SLOW_BIT_CYC(13'd16)) u_scp_command_parser (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .displayBitSharedRx(rxLine), .displayBitSharedTx(txLine), .maskOut(maskOut),
    .dispReq(dispReq), .dispGrant(dispGrant), .voltmeterInput(voltmeterInput),
    .counterInput(counterInput), .auxOutput0(auxOutput0), .auxOutput1(auxOutput1));

  scp_host_model #(.BIT_CYC(16)) u_scp_host_model (
    .sys_clk(sys_clk), .serialIn(txLine), .serialOut(rxLine));

  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input string exp, input string got);
    checked++;
    if (got != exp) begin
      failures++;
      $display("unexpected %s: expected %s, seen %s", what, exp, got);
    end
  endtask : check

  // one edge left idle after release, so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // trailing wait catches any extra or unwanted reply
  task automatic xfer(input string cmd, input string exp);
    string got;
    got = "";
    u_scp_host_model.rxQ.delete();
    u_scp_host_model.send_str(cmd);
    for (int t = 0; t < 8000 && u_scp_host_model.rxQ.size() < exp.len(); t++)
      @(posedge sys_clk);
    repeat (300) @(posedge sys_clk);
    foreach (u_scp_host_model.rxQ[i]) got = $sformatf("%s%c", got, u_scp_host_model.rxQ[i]);
    check(cmd, exp, got);
  endtask : xfer

  initial begin
    repeat (95000) @(posedge sys_clk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    apb(1'b1, `SCP_OFS_CTRL, 32'h0000_0001);
    apb(1'b0, `SCP_OFS_CTRL, 32'h0);
    check("ctrl", "00000001", $sformatf("%h", rd));
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", "100000000", $sformatf("%b%h", err, rd));
    xfer("FA7030000;", "");
    xfer("FA;", "FA00007030000;");
    apb(1'b0, `SCP_OFS_VFO_A, 32'h0);
    check("vfo a word", "07030000", $sformatf("%h", rd));
    xfer("FB99999999999;", "");
    xfer("FB;", "FB99999999999;");
    xfer("FA1234567890123456789;", "");
    xfer("FA;", "FA00007030000;");
    xfer("QQ;", "?;");
    xfer("AG;", "AG0000;");
    xfer("FW1;", "FW0200;");
    xfer("ID;", $sformatf("ID%h;", `SCP_RADIO_IDENTITY));
    xfer("AX2;", "");
    check("aux", "10", $sformatf("%b%b", auxOutput1, auxOutput0));
    apb(1'b0, `SCP_OFS_STATUS, 32'h0);
    check("status", "00000008", $sformatf("%h", rd));
    counterInput <= 1'b1;
    xfer("AX;", "AX34;");
    voltmeterInput <= 1'b1;
    counterInput <= 1'b0;
    xfer("AX;", "AX6;");
    for (int m = 0; m < 3; m++) begin
      xfer($sformatf("F%s%0d;", m == 1 ? "R" : "T", m), "");
      xfer("FR;", $sformatf("FR%0d;", m == 1));
      xfer("FT;", $sformatf("FT%0d;", m != 0));
      // split while transmitting must report vfo B
      if (m == 2) apb(1'b1, `SCP_OFS_CTRL, 32'h1234_000F);
      f = (m == 0) ? "00007030000" : "99999999999";
      xfer("IF;", $sformatf("IF%s     %s%0d0000%0d3%0d0%0d00 ;", f, m == 2 ? "-1234" : "+0000",
        m == 2, m == 2, m == 1, m == 2));
    end
    dispReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("grant", "111", $sformatf("%b%b%b", dispGrant, maskOut, txLine));
    xfer("FA;", "");
    dispReq <= 1'b0;
    repeat (300) @(posedge sys_clk);
    check("lost", "0", $sformatf("%0d", u_scp_host_model.rxQ.size()));
    finish_test();
  end
endmodule : serial_remote_command_parser_tb
